// file: hw/hbd_pkg.sv
// Shared constants and types for the host bus port and its host end
package hbd_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic STYLE_STROBE_DIR = 1'b1;
    localparam logic STYLE_SEPARATE = 1'b0;
    localparam logic [7:0] RESET_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] RESET_ADDR = 8'h00;

    typedef enum logic [2:0] {
        HBD_NONE = 3'b000,
        HBD_REG_RD = 3'b001,
        HBD_REG_WR = 3'b010,
        HBD_DMA_RD = 3'b011,
        HBD_DMA_WR = 3'b100
    } hbd_kind_t;
endpackage

// file: hw/hbd_bus_if.sv
// Host parallel bus between the host end and the device port
`timescale 1ns/1ps
`default_nettype none
interface hbd_bus_if;
    import hbd_pkg::*;
    logic style_sel;
    logic cs_n;
    logic dma_ack_n;
    logic data_strobe_n;
    logic rd_wr_n;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic [ADDR_W-1:0] addr_o;
    logic [ADDR_W-1:0] addr_oe;
    logic [DATA_W-1:0] host_d_o;
    logic host_d_oe;
    logic [DATA_W-1:0] dev_d_o;
    logic dev_d_oe;
    logic [DATA_W-1:0] d;
    logic dma_tx_request;
    logic dma_rx_request;

    // Resolved data bus; contention resolves to device value
    assign d = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : '0);

    modport dev (
        input style_sel, cs_n, dma_ack_n, data_strobe_n, rd_wr_n, rd_n, wr_n, ale,
        input addr_o, host_d_o, host_d_oe, d,
        output dev_d_o, dev_d_oe, dma_tx_request, dma_rx_request
    );
    modport host (
        output style_sel, cs_n, dma_ack_n, data_strobe_n, rd_wr_n, rd_n, wr_n, ale,
        output addr_o, addr_oe, host_d_o, host_d_oe,
        input d, dev_d_oe, dma_tx_request, dma_rx_request
    );
endinterface
`default_nettype wire

// file: hw/hbd_device.sv
// Device end of the host bus: style decode, DMA direction and data drive
//
// Operation
// RQ1: Separate strobes, normal DMA: R high=write, else read
// RQ2: Fly-by inverts separate-strobe DMA direction
// RQ3: Host holds direction steady through fly-by DMA
// RQ4: Fly-by: read strobe times writes, write times reads
// RQ5: Latch style select at reset release
// RQ6: Strobe-direction style demultiplexed only; ALE picks mux
// RQ7: Register access active while strobe and select low
// RQ8: Direction line picks read or write; strobe times
// RQ9: Host presents address with select and strobe
// RQ10: DMA acknowledge alone marks DMA, no select
// RQ11: Direction low DMA write normally; fly-by inverts
// RQ12: Fly-by is a software setting in control register
// RQ13: Drive data only during read strobe, then release
`timescale 1ns/1ps
`default_nettype none
module hbd_device (
    input wire logic clk,
    input wire logic rst,
    hbd_bus_if.dev bus,
    input wire logic fly_by_en,
    input wire logic dma_tx_pending,
    input wire logic dma_rx_pending,
    input wire logic [hbd_pkg::DATA_W-1:0] reg_rd_data,
    input wire logic [hbd_pkg::DATA_W-1:0] dma_rd_data,
    output logic style_reg,
    output logic fly_by_reg,
    output logic [hbd_pkg::ADDR_W-1:0] access_addr,
    output logic [hbd_pkg::DATA_W-1:0] wr_data,
    output logic reg_wr_pulse,
    output logic reg_rd_pulse,
    output logic dma_wr_pulse,
    output logic dma_rd_pulse,
    output logic muxed_addr
);
    import hbd_pkg::*;

    logic rst_d_reg;
    logic [ADDR_W-1:0] addr_latch_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wr_data_reg;
    logic [DATA_W-1:0] dout_reg;
    logic oe_reg;
    logic active_reg;
    hbd_kind_t kind_reg;
    logic ale_low_reg;

    wire is_dma = !bus.dma_ack_n; // RQ10
    wire qualified_data_strobe = !bus.data_strobe_n && !bus.cs_n; // RQ7
    wire dir_strobe = !bus.data_strobe_n && is_dma;
    wire sep_rd = !bus.rd_n && bus.wr_n;
    wire sep_wr = !bus.wr_n && bus.rd_n;
    // Separate style DMA: pattern R high/W low is write in normal mode
    wire sep_dma_wr = fly_by_reg ? sep_rd : sep_wr; // RQ1 RQ2 RQ4
    wire sep_dma_rd = fly_by_reg ? sep_wr : sep_rd; // RQ1 RQ2 RQ4
    // Strobe-direction style: direction low is DMA write in normal mode
    wire dir_dma_wr = fly_by_reg ? bus.rd_wr_n : !bus.rd_wr_n; // RQ11 RQ3
    wire sep_reg_act = !bus.cs_n && (sep_rd || sep_wr) && !is_dma;
    wire dir_reg_act = qualified_data_strobe && !is_dma;
    wire act_now = (style_reg == STYLE_STROBE_DIR)
        ? (dir_reg_act || dir_strobe)
        : (sep_reg_act || (is_dma && (sep_rd || sep_wr)));
    hbd_kind_t kind_now;
    always_comb begin
        kind_now = HBD_NONE;
        if (style_reg == STYLE_STROBE_DIR) begin
            if (dir_strobe)
                kind_now = dir_dma_wr ? HBD_DMA_WR : HBD_DMA_RD;
            else if (dir_reg_act)
                kind_now = bus.rd_wr_n ? HBD_REG_RD : HBD_REG_WR; // RQ8
        end else begin
            if (is_dma && sep_dma_wr)
                kind_now = HBD_DMA_WR;
            else if (is_dma && sep_dma_rd)
                kind_now = HBD_DMA_RD;
            else if (sep_reg_act)
                kind_now = sep_rd ? HBD_REG_RD : HBD_REG_WR;
        end
    end
    wire is_read_now = (kind_now == HBD_REG_RD) || (kind_now == HBD_DMA_RD);
    // ALE held high all the time means demultiplexed; seeing it low means multiplexed
    wire mux_mode = (style_reg == STYLE_SEPARATE) && ale_low_reg; // RQ6
    wire [ADDR_W-1:0] addr_now = mux_mode ? addr_latch_reg : bus.addr_o;
    wire end_now = active_reg && !act_now; // RQ7

    always_ff @(posedge clk) begin
        rst_d_reg <= rst;
        if (rst_d_reg && !rst)
            style_reg <= bus.style_sel; // RQ5
        if (rst)
            fly_by_reg <= 1'b0;
        else
            fly_by_reg <= fly_by_en; // RQ12
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addr_latch_reg <= RESET_ADDR;
            ale_low_reg <= 1'b0;
        end else begin
            if (bus.ale && style_reg == STYLE_SEPARATE)
                addr_latch_reg <= bus.d;
            if (!bus.ale)
                ale_low_reg <= 1'b1; // RQ6
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active_reg <= 1'b0;
            kind_reg <= HBD_NONE;
            addr_reg <= RESET_ADDR;
            wr_data_reg <= RESET_DATA;
            dout_reg <= RESET_DATA;
            oe_reg <= 1'b0;
        end else begin
            active_reg <= act_now;
            if (act_now) begin
                kind_reg <= kind_now;
                addr_reg <= addr_now;
                wr_data_reg <= bus.d;
            end
            oe_reg <= act_now && is_read_now; // RQ13
            dout_reg <= (kind_now == HBD_DMA_RD) ? dma_rd_data : reg_rd_data;
        end
    end

    assign bus.dev_d_o = dout_reg;
    assign bus.dev_d_oe = oe_reg && act_now; // RQ13
    assign bus.dma_tx_request = dma_tx_pending;
    assign bus.dma_rx_request = dma_rx_pending;
    assign access_addr = addr_reg;
    assign wr_data = wr_data_reg;
    assign reg_wr_pulse = end_now && kind_reg == HBD_REG_WR;
    assign reg_rd_pulse = end_now && kind_reg == HBD_REG_RD;
    assign dma_wr_pulse = end_now && kind_reg == HBD_DMA_WR;
    assign dma_rd_pulse = end_now && kind_reg == HBD_DMA_RD;
    assign muxed_addr = mux_mode;
endmodule
`default_nettype wire

// file: hw/hbd_host.sv
// Host end of the bus: runs one register or DMA access per request
`timescale 1ns/1ps
`default_nettype none
module hbd_host (
    input wire logic clk,
    input wire logic rst,
    hbd_bus_if.host bus,
    input wire logic style_cfg,
    input wire logic fly_by_cfg,
    input wire logic mux_cfg,
    input wire logic req_valid,
    input wire hbd_pkg::hbd_kind_t req_kind,
    input wire logic [hbd_pkg::ADDR_W-1:0] req_addr,
    input wire logic [hbd_pkg::DATA_W-1:0] req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic [hbd_pkg::DATA_W-1:0] rsp_data
);
    import hbd_pkg::*;

    typedef enum logic [1:0] {
        HBH_IDLE = 2'b00,
        HBH_ALE = 2'b01,
        HBH_STROBE = 2'b10,
        HBH_END = 2'b11
    } hbh_state_t;

    hbh_state_t state_reg;
    hbd_kind_t kind_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] rsp_reg;
    logic rsp_v_reg;
    // Strobe stands two cycles so the registered read data is on the bus when taken
    logic wait_reg;

    wire is_dma = kind_reg == HBD_DMA_RD || kind_reg == HBD_DMA_WR;
    wire is_wr = kind_reg == HBD_REG_WR || kind_reg == HBD_DMA_WR;
    wire strobing = state_reg == HBH_STROBE;
    wire use_mux = mux_cfg && style_cfg == STYLE_SEPARATE;
    // Separate style fly-by DMA swaps which strobe is pulsed
    wire pulse_rd = is_dma && fly_by_cfg ? is_wr : !is_wr; // RQ4
    // Direction line: register read high; DMA per fly-by setting
    wire dir_level = is_dma ? (fly_by_cfg ? is_wr : !is_wr) : !is_wr; // RQ3 RQ11 RQ8

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= HBH_IDLE;
            kind_reg <= HBD_NONE;
            addr_reg <= RESET_ADDR;
            data_reg <= RESET_DATA;
            rsp_reg <= RESET_DATA;
            rsp_v_reg <= 1'b0;
            wait_reg <= 1'b0;
        end else begin
            rsp_v_reg <= 1'b0;
            unique case (state_reg)
                HBH_IDLE: if (req_valid && req_kind != HBD_NONE) begin
                    kind_reg <= req_kind;
                    addr_reg <= req_addr;
                    data_reg <= req_data;
                    state_reg <= use_mux ? HBH_ALE : HBH_STROBE;
                end
                HBH_ALE: state_reg <= HBH_STROBE;
                HBH_STROBE: begin
                    if (!wait_reg) begin
                        wait_reg <= 1'b1;
                    end else begin
                        wait_reg <= 1'b0;
                        rsp_reg <= bus.d;
                        state_reg <= HBH_END;
                    end
                end
                HBH_END: begin
                    rsp_v_reg <= !is_wr;
                    state_reg <= HBH_IDLE;
                end
            endcase
        end
    end

    assign bus.style_sel = style_cfg;
    assign bus.cs_n = !(strobing && !is_dma); // RQ9 RQ10
    assign bus.dma_ack_n = !(state_reg != HBH_IDLE && is_dma); // RQ10
    assign bus.data_strobe_n = !(strobing && style_cfg == STYLE_STROBE_DIR);
    assign bus.rd_wr_n = state_reg != HBH_IDLE ? dir_level : 1'b1;
    assign bus.rd_n = !(strobing && style_cfg == STYLE_SEPARATE && pulse_rd); // RQ1
    assign bus.wr_n = !(strobing && style_cfg == STYLE_SEPARATE && !pulse_rd); // RQ1
    // ALE held high for demultiplexed operation
    assign bus.ale = use_mux ? state_reg == HBH_ALE : 1'b1; // RQ6
    assign bus.addr_o = addr_reg;
    assign bus.addr_oe = '1;
    assign bus.host_d_o = state_reg == HBH_ALE ? addr_reg : data_reg;
    assign bus.host_d_oe = state_reg == HBH_ALE || (strobing && is_wr);
    assign req_ready = state_reg == HBH_IDLE;
    assign rsp_valid = rsp_v_reg;
    assign rsp_data = rsp_reg;
endmodule
`default_nettype wire

// file: verif/hbd_bus_assertions.sv
// Concurrent checks on the host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module hbd_bus_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic style_sel,
    input wire logic cs_n,
    input wire logic dma_ack_n,
    input wire logic data_strobe_n,
    input wire logic rd_wr_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic dev_d_oe,
    input wire logic style_reg,
    input wire logic fly_by_reg,
    input wire logic reg_wr_pulse,
    input wire logic reg_rd_pulse,
    input wire logic dma_wr_pulse,
    input wire logic dma_rd_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic sel = !cs_n || !dma_ack_n;
    wire logic act = style_reg ? (!data_strobe_n && sel) : ((rd_n ^ wr_n) && sel);
    wire logic dwr = style_reg ? !(rd_wr_n ^ fly_by_reg) : (rd_n ^ fly_by_reg);
    wire logic rwr = style_reg ? !rd_wr_n : !wr_n;
    wire logic rdl = !dma_ack_n ? !dwr : !rwr;
    wire logic any_p = reg_wr_pulse || reg_rd_pulse || dma_wr_pulse || dma_rd_pulse;
    // Last active cycle of an access, then the first idle one
    sequence s_done(c);
        act && c ##1 !act;
    endsequence
    a_dma_wr_dir: assert property (
        s_done(!dma_ack_n && dwr) |-> dma_wr_pulse && !dma_rd_pulse) else $error("dma write");
    a_dma_rd_dir: assert property (
        s_done(!dma_ack_n && !dwr) |-> dma_rd_pulse && !dma_wr_pulse) else $error("dma read");
    a_reg_wr_end: assert property (
        s_done(dma_ack_n && rwr) |-> reg_wr_pulse && !reg_rd_pulse) else $error("reg write");
    a_reg_rd_end: assert property (
        s_done(dma_ack_n && !rwr) |-> reg_rd_pulse && !reg_wr_pulse) else $error("reg read");
    a_no_idle_pulse: assert property (
        !$past(act) |-> !any_p) else $error("pulse without access");
    a_oe_read_only: assert property (
        dev_d_oe |-> act && rdl) else $error("data driven outside read");
    a_oe_read_rise: assert property (
        act && rdl ##1 act && rdl |-> dev_d_oe) else $error("read data not driven");
    a_style_capture: assert property (
        $past(rst) && !rst |=> style_reg == $past(style_sel)) else $error("style not taken");
    a_style_hold: assert property (
        !$past(rst, 2) |-> $stable(style_reg)) else $error("style changed");
endmodule
`default_nettype wire

// file: verif/host_bus_dma_strobe_decode_tb_top.sv
// Bench running register and DMA transfers across both bus ends
`timescale 1ns/1ps
`default_nettype none
module host_bus_dma_strobe_decode_tb_top;
    import hbd_pkg::*;
    logic clk, rst, sty, fly, mux, rv, rdy, rspv, tp, rp, sreg, freg, rg_w, rg_r, dm_w, dm_r, muxd;
    int n_end = 0;
    int n_rsp = 0;
    logic [7:0] exp_q[$];
    hbd_kind_t kind;
    logic [7:0] ad, wd, rdd, dmd, rsp, acc, wrd, got;
    logic [3:0] seen;
    int fails, num_checks;
    hbd_bus_if bus ();
    hbd_device hbd_device_i (.clk(clk), .rst(rst), .bus(bus), .fly_by_en(fly),
        .dma_tx_pending(tp), .dma_rx_pending(rp), .reg_rd_data(rdd), .dma_rd_data(dmd),
        .style_reg(sreg), .fly_by_reg(freg), .access_addr(acc), .wr_data(wrd),
        .reg_wr_pulse(rg_w), .reg_rd_pulse(rg_r), .dma_wr_pulse(dm_w), .dma_rd_pulse(dm_r),
        .muxed_addr(muxd));
    hbd_host hbd_host_i (.clk(clk), .rst(rst), .bus(bus), .style_cfg(sty), .fly_by_cfg(fly),
        .mux_cfg(mux), .req_valid(rv), .req_kind(kind), .req_addr(ad), .req_data(wd),
        .req_ready(rdy), .rsp_valid(rspv), .rsp_data(rsp));
    hbd_bus_assertions chk_i (.clk(clk), .rst(rst), .style_sel(bus.style_sel),
        .cs_n(bus.cs_n), .dma_ack_n(bus.dma_ack_n), .data_strobe_n(bus.data_strobe_n),
        .rd_wr_n(bus.rd_wr_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .dev_d_oe(bus.dev_d_oe),
        .style_reg(sreg), .fly_by_reg(freg), .reg_wr_pulse(rg_w), .reg_rd_pulse(rg_r),
        .dma_wr_pulse(dm_w), .dma_rd_pulse(dm_r));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Captures which end-of-access pulse fired and the read response
    always @(posedge clk) begin
        if (rg_r || rg_w || dm_r || dm_w) begin
            seen <= {dm_w, dm_r, rg_w, rg_r};
            n_end <= n_end + 1;
        end
        if (rspv) begin
            got <= rsp;
            n_rsp <= n_rsp + 1;
        end
    end
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task xfer(input int k);
        int n, e0, r0;
        kind = hbd_kind_t'(k);
        {ad, wd, rdd, dmd} = $urandom;
        {tp, rp} = 2'($urandom);
        if (k[0])
            exp_q.push_back(k == 3 ? dmd : rdd);
        e0 = n_end;
        r0 = n_rsp;
        for (n = 0; !rdy && n < 50; n++) @(negedge clk);
        if (!rdy) begin
            fails++;
            give_verdict;
        end
        rv = 1'b1;
        @(negedge clk);
        rv = 1'b0;
        for (n = 0; (n_end == e0 || (k[0] && n_rsp == r0)) && n < 50; n++) @(negedge clk);
        if (n == 50) begin
            fails++;
            give_verdict;
        end
        chk("kind", {4'h0, seen}, 8'h01 << (k - 1));
        if (k[0])
            chk("rdata", got, exp_q.pop_front());
        else
            chk("wdata", wrd, wd);
        if (k < 3)
            chk("addr", acc, ad);
        chk("txreq", {7'h00, bus.dma_tx_request}, {7'h00, tp});
        chk("rxreq", {7'h00, bus.dma_rx_request}, {7'h00, rp});
    endtask
    initial begin
        {sty, fly, mux, rv, tp, rp} = 6'h00;
        {ad, wd, rdd, dmd} = 32'h0;
        rst = 1'b1;
        kind = HBD_NONE;
        void'($urandom(68));
        for (int c = 0; c < 4; c++) begin
            rst = 1'b1;
            {sty, fly} = 2'(c);
            mux = !sty && 1'($urandom);
            repeat (20) @(negedge clk);
            rst = 1'b0;
            repeat (2) @(negedge clk);
            chk("style", {7'h00, sreg}, {7'h00, sty});
            chk("flyby", {7'h00, freg}, {7'h00, fly});
            chk("muxed", {7'h00, muxd}, {7'h00, mux});
            for (int k = 0; k < 8; k++) xfer(k % 4 + 1);
            $display("test %0d done", c);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
